// *** rtl/pmr_register_bank.sv ***
// Functional notes
// R01: registers reached only by system-register read and write, no memory map
// R02: identification field in bits 43..0, bits 63..44 read zero
// R03: identification bit reads 1 when event implemented, 0 when not
// R04: bits 43, 41, 38, 37 read 1 for implemented slow-miss and stall events
// R05: bits 42, 40, 39 read 0
// R06: exactly six event counters, reported in control counter-number field
`include "pmr_defines.svh"
`timescale 1ns/100ps
module pmr_register_bank (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        sys_req,
    input  wire logic        sys_write,
    input  wire logic [4:0]  sys_index,
    input  wire logic [63:0] sys_wdata,
    input  wire logic [5:0]  event_pulse,
    output logic             sys_ack,
    output logic [63:0]      sys_rdata,
    output logic             sys_unmapped,
    output logic             count_enable_all,
    output logic [31:0]      overflow_flags
);
    // ==========================================================
    // reset
    logic rst_n;

    pmr_sync_reset u_rst (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .rst_n   (rst_n)
    );

    // ==========================================================
    // state
    pmr_pkg::pmr_acc_state_t state_reg;
    pmr_pkg::pmr_acc_state_t state_next;
    logic [31:0]             ctrl_reg;
    logic [31:0]             cen_reg;
    logic [31:0]             ovf_reg;
    logic [31:0]             irq_en_reg;
    logic [4:0]              sel_reg;
    logic [31:0]             user_en_reg;
    logic [31:0]             cyc_filt_reg;
    logic [63:0]             cycle_reg;
    logic [31:0]             evcnt_reg  [0:5];
    logic [31:0]             evtype_reg [0:5];

    // ==========================================================
    // decode
    function automatic logic [2:0] slot_of(input logic [4:0] idx,
                                           input logic [4:0] base);
        logic [4:0] diff;
        diff = idx - base;
        slot_of = diff[2:0];
    endfunction : slot_of

    function automatic logic in_bank(input logic [4:0] idx,
                                     input logic [4:0] base);
        in_bank = (idx >= base) && (idx < base + `PMR_NUM_COUNTERS);
    endfunction : in_bank

    wire       take       = sys_req && (state_reg == pmr_pkg::PMR_ACC_IDLE);
    wire       wr         = take && sys_write; // R01
    wire [31:0] wd        = sys_wdata[31:0];
    wire       hit_evcnt  = in_bank(sys_index, `PMR_IDX_EVCNT0);
    wire       hit_evtype = in_bank(sys_index, `PMR_IDX_EVTYPE0);
    wire [2:0] ev_slot    = slot_of(sys_index, `PMR_IDX_EVCNT0);
    wire [2:0] ty_slot    = slot_of(sys_index, `PMR_IDX_EVTYPE0);
    wire       sel_valid  = sel_reg < `PMR_NUM_COUNTERS; // R06
    wire [2:0] sel_slot   = sel_reg[2:0];
    wire       mapped     = (sys_index <= `PMR_IDX_OVF_SET)
                            || hit_evcnt || hit_evtype;
    wire       wr_ctrl    = wr && sys_index == `PMR_IDX_CTRL;
    wire       ev_reset   = wr_ctrl && wd[`PMR_CTRL_EV_RESET];
    wire       cy_reset   = wr_ctrl && wd[`PMR_CTRL_CY_RESET];
    wire       enabled    = ctrl_reg[`PMR_CTRL_ENABLE];
    wire [31:0] sw_inc    = (wr && sys_index == `PMR_IDX_SW_INC)
                            ? (wd & 32'h0000003f) : 32'h00000000;

    // control: counter count field constant, only rw bits stored
    wire [31:0] ctrl_view = (ctrl_reg & `PMR_CTRL_RW_MASK)
        | ({27'h0000000, `PMR_NUM_COUNTERS} << `PMR_CTRL_N_LSB); // R06

    // ==========================================================
    // read mux
    logic [63:0] rd_mux;

    always_comb begin
        rd_mux = 64'h0000000000000000;
        if (hit_evcnt) begin
            rd_mux = {32'h00000000, evcnt_reg[ev_slot]};
        end else if (hit_evtype) begin
            rd_mux = {32'h00000000, evtype_reg[ty_slot]};
        end else begin
            unique case (sys_index)
                `PMR_IDX_CTRL:     rd_mux = {32'h00000000, ctrl_view};
                `PMR_IDX_CEN_SET,
                `PMR_IDX_CEN_CLR:  rd_mux = {32'h00000000, cen_reg};
                `PMR_IDX_OVF_CLR,
                `PMR_IDX_OVF_SET:  rd_mux = {32'h00000000, ovf_reg};
                `PMR_IDX_SEL:      rd_mux = {59'h0, sel_reg};
                // R02 R03 R04 R05
                `PMR_IDX_CEID_LO:  rd_mux = `PMR_CEID_LO_VAL;
                `PMR_IDX_CEID_HI:  rd_mux = `PMR_CEID_HI_VAL;
                `PMR_IDX_CYCLE:    rd_mux = cycle_reg;
                `PMR_IDX_SEL_TYPE: rd_mux = sel_valid
                    ? {32'h00000000, evtype_reg[sel_slot]} : 64'h0;
                `PMR_IDX_CYC_FILT: rd_mux = {32'h00000000, cyc_filt_reg};
                `PMR_IDX_SEL_CNT:  rd_mux = sel_valid
                    ? {32'h00000000, evcnt_reg[sel_slot]} : 64'h0;
                `PMR_IDX_USER_EN:  rd_mux = {32'h00000000, user_en_reg};
                `PMR_IDX_IRQ_SET,
                `PMR_IDX_IRQ_CLR:  rd_mux = {32'h00000000, irq_en_reg};
                default:           rd_mux = 64'h0000000000000000;
            endcase
        end
    end

    // ==========================================================
    // access sequencer: one-cycle reply after each taken request
    always_comb begin
        unique case (state_reg)
            pmr_pkg::PMR_ACC_IDLE:
                state_next = sys_req ? pmr_pkg::PMR_ACC_REPLY
                                     : pmr_pkg::PMR_ACC_IDLE;
            pmr_pkg::PMR_ACC_REPLY: state_next = pmr_pkg::PMR_ACC_IDLE;
            default:                state_next = pmr_pkg::PMR_ACC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= pmr_pkg::PMR_ACC_IDLE;
            sys_ack      <= 1'b0;
            sys_rdata    <= 64'h0000000000000000;
            sys_unmapped <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sys_ack      <= take;
            // write-only index reads zero
            sys_rdata    <= (take && !sys_write) ? rd_mux : 64'h0;
            sys_unmapped <= take && !mapped;
        end
    end

    // ==========================================================
    // control, enables, overflow, selection
    wire [31:0] cen_next = (wr && sys_index == `PMR_IDX_CEN_SET)
        ? (cen_reg | (wd & `PMR_CTR_MASK))
        : (wr && sys_index == `PMR_IDX_CEN_CLR)
        ? (cen_reg & ~wd) : cen_reg;
    wire [31:0] irq_next = (wr && sys_index == `PMR_IDX_IRQ_SET)
        ? (irq_en_reg | (wd & `PMR_CTR_MASK))
        : (wr && sys_index == `PMR_IDX_IRQ_CLR)
        ? (irq_en_reg & ~wd) : irq_en_reg;

    // overflow events from counters wrapping
    logic [31:0] ovf_event;
    logic [31:0] ovf_next;

    always_comb begin
        ovf_next = ovf_reg;
        if (wr && sys_index == `PMR_IDX_OVF_CLR) begin
            ovf_next = ovf_reg & ~wd;
        end
        if (wr && sys_index == `PMR_IDX_OVF_SET) begin
            ovf_next = ovf_reg | (wd & `PMR_CTR_MASK);
        end
        // set beats clear
        ovf_next = ovf_next | ovf_event;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= 32'h00000000;
            cen_reg      <= 32'h00000000;
            irq_en_reg   <= 32'h00000000;
            ovf_reg      <= 32'h00000000;
            sel_reg      <= 5'h00;
            user_en_reg  <= 32'h00000000;
            cyc_filt_reg <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wd & `PMR_CTRL_RW_MASK;
            end
            if (wr && sys_index == `PMR_IDX_SEL) begin
                sel_reg <= wd[4:0];
            end
            if (wr && sys_index == `PMR_IDX_USER_EN) begin
                user_en_reg <= wd;
            end
            if (wr && sys_index == `PMR_IDX_CYC_FILT) begin
                cyc_filt_reg <= wd;
            end
            cen_reg    <= cen_next;
            irq_en_reg <= irq_next;
            ovf_reg    <= ovf_next;
        end
    end

    // ==========================================================
    // cycle counter; overflow of bit 63 when long mode, else bit 31
    wire cyc_run   = enabled && cen_reg[31];
    wire cyc_long  = ctrl_reg[6];
    wire cyc_wrap  = cyc_run && (cyc_long ? &cycle_reg : &cycle_reg[31:0]);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_reg <= 64'h0000000000000000;
        end else if (cy_reset) begin
            cycle_reg <= 64'h0000000000000000;
        end else if (wr && sys_index == `PMR_IDX_CYCLE) begin
            cycle_reg <= sys_wdata;
        end else if (cyc_run) begin
            cycle_reg <= cycle_reg + 64'h0000000000000001;
        end
    end

    // ==========================================================
    // six event counters and type registers
    assign ovf_event[31]    = cyc_wrap;
    assign ovf_event[30:6]  = 25'h0000000;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_ctr // R06
            wire hit_c  = (hit_evcnt && ev_slot == 3'(gi))
                          || (sys_index == `PMR_IDX_SEL_CNT
                              && sel_valid && sel_slot == 3'(gi));
            wire hit_t  = (hit_evtype && ty_slot == 3'(gi))
                          || (sys_index == `PMR_IDX_SEL_TYPE
                              && sel_valid && sel_slot == 3'(gi));
            wire bump   = (enabled && cen_reg[gi] && event_pulse[gi])
                          || sw_inc[gi];
            assign ovf_event[gi] = bump && (&evcnt_reg[gi]);

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    evcnt_reg[gi]  <= 32'h00000000;
                    evtype_reg[gi] <= 32'h00000000;
                end else begin
                    if (ev_reset) begin
                        evcnt_reg[gi] <= 32'h00000000;
                    end else if (wr && hit_c) begin
                        evcnt_reg[gi] <= wd;
                    end else if (bump) begin
                        evcnt_reg[gi] <= evcnt_reg[gi] + 32'h00000001;
                    end
                    if (wr && hit_t) begin
                        evtype_reg[gi] <= wd;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // status outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_enable_all <= 1'b0;
            overflow_flags   <= 32'h00000000;
        end else begin
            count_enable_all <= enabled;
            overflow_flags   <= ovf_next;
        end
    end
endmodule : pmr_register_bank

// *** rtl/pmr_defines.svh ***
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// ==========================================================
// register indices on the system-register port
`define PMR_IDX_CTRL        5'h00
`define PMR_IDX_CEN_SET     5'h01
`define PMR_IDX_CEN_CLR     5'h02
`define PMR_IDX_OVF_CLR     5'h03
`define PMR_IDX_SW_INC      5'h04
`define PMR_IDX_SEL         5'h05
`define PMR_IDX_CEID_LO     5'h06
`define PMR_IDX_CEID_HI     5'h07
`define PMR_IDX_CYCLE       5'h08
`define PMR_IDX_SEL_TYPE    5'h09
`define PMR_IDX_CYC_FILT    5'h0a
`define PMR_IDX_SEL_CNT     5'h0b
`define PMR_IDX_USER_EN     5'h0c
`define PMR_IDX_IRQ_SET     5'h0d
`define PMR_IDX_IRQ_CLR     5'h0e
`define PMR_IDX_OVF_SET     5'h0f
`define PMR_IDX_EVCNT0      5'h10
`define PMR_IDX_EVTYPE0     5'h16

// ==========================================================
// identification words and control layout
`define PMR_CEID_LO_VAL     64'h00000a7f7fff0f3f
`define PMR_CEID_HI_VAL     64'h00000000fef2ae7f
`define PMR_NUM_COUNTERS    5'h06
`define PMR_CTRL_N_LSB      11
`define PMR_CTRL_ENABLE     0
`define PMR_CTRL_EV_RESET   1
`define PMR_CTRL_CY_RESET   2
`define PMR_CTRL_RW_MASK    32'h0000007d
`define PMR_CTR_MASK        32'h8000003f

`endif

// *** rtl/pmr_pkg.sv ***
package pmr_pkg;
    typedef enum logic [1:0] {
        PMR_ACC_IDLE  = 2'b01,
        PMR_ACC_REPLY = 2'b10
    } pmr_acc_state_t;
    typedef logic [31:0] pmr_word_t;
endpackage : pmr_pkg

// *** rtl/pmr_sync_reset.sv ***
`timescale 1ns/100ps
module pmr_sync_reset (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    output logic      rst_n
);
    logic stage_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            stage_reg <= 1'b1;
            rst_n     <= stage_reg;
        end
    end
endmodule : pmr_sync_reset

// *** tb/pmr_register_bank_sva.sv ***
`include "pmr_defines.svh"
`timescale 1ns/100ps
module pmr_register_bank_sva (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        sys_req,
    input wire logic        sys_write,
    input wire logic [4:0]  sys_index,
    input wire logic [63:0] sys_wdata,
    input wire logic [5:0]  event_pulse,
    input wire logic        sys_ack,
    input wire logic [63:0] sys_rdata,
    input wire logic        sys_unmapped,
    input wire logic        count_enable_all,
    input wire logic [31:0] overflow_flags
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // request accepted only while no answer is standing
    wire logic taken;
    assign taken = sys_req && !sys_ack;
    sequence s_rd_lo;
        taken && !sys_write && sys_index == 5'h06;
    endsequence
    property p_ack_latency;
        taken |=> sys_ack;
    endproperty
    a_ack_latency: assert property (p_ack_latency)
        else $error("no answer one cycle after a request");
    property p_ack_cause;
        sys_ack |-> $past(sys_req) && !$past(sys_ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("answer without a preceding request");
    property p_idle_data;
        !sys_ack |-> sys_rdata == 64'h0 && !sys_unmapped;
    endproperty
    a_idle_data: assert property (p_idle_data)
        else $error("read data or unmapped flag outside an answer");
    property p_unmapped;
        taken && sys_index > 5'h1b |=> sys_ack && sys_unmapped;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped index not flagged");
    property p_lo_reserved;
        s_rd_lo |=> sys_rdata[63:44] == 20'h00000;
    endproperty
    a_lo_reserved: assert property (p_lo_reserved)
        else $error("reserved identification bits not zero");
    property p_lo_value;
        s_rd_lo |=> sys_rdata == 64'h00000a7f7fff0f3f;
    endproperty
    a_lo_value: assert property (p_lo_value)
        else $error("identification word wrong");
    property p_lo_present;
        s_rd_lo |=> sys_rdata[43] && sys_rdata[41]
            && sys_rdata[38:37] == 2'h3;
    endproperty
    a_lo_present: assert property (p_lo_present)
        else $error("implemented event bit reads zero");
    property p_lo_absent;
        s_rd_lo |=> !sys_rdata[42] && sys_rdata[40:39] == 2'h0;
    endproperty
    a_lo_absent: assert property (p_lo_absent)
        else $error("absent event bit reads one");
    property p_ctrl_count;
        taken && !sys_write && sys_index == 5'h00
            |=> sys_rdata[15:11] == 5'h06;
    endproperty
    a_ctrl_count: assert property (p_ctrl_count)
        else $error("counter number field wrong");
    c_read_lo: cover property (s_rd_lo);
    c_unmapped: cover property (sys_unmapped);
    c_refused: cover property (sys_req && sys_ack);
endmodule : pmr_register_bank_sva

// *** tb/pmr_register_bank_tb.sv ***
`timescale 1ns/100ps
module pmr_register_bank_tb;
    logic        ref_clk     = 1'b0;
    logic        arst_n      = 1'b0;
    logic        sys_req     = 1'b0;
    logic        sys_write   = 1'b0;
    logic [4:0]  sys_index   = 5'h00;
    logic [63:0] sys_wdata   = 64'h0;
    logic [5:0]  event_pulse = 6'h00;
    logic        sys_ack;
    logic        sys_unmapped;
    logic        count_enable_all;
    logic [63:0] sys_rdata;
    logic [31:0] overflow_flags;
    logic [63:0] rd;
    logic        unm;
    int          err_total   = 0;
    int          check_count = 0;
    int          cycles      = 0;
    always #12.5 ref_clk = ~ref_clk;
    pmr_register_bank uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .sys_req(sys_req), .sys_write(sys_write), .sys_index(sys_index),
        .sys_wdata(sys_wdata), .event_pulse(event_pulse), .sys_ack(sys_ack),
        .sys_rdata(sys_rdata), .sys_unmapped(sys_unmapped),
        .count_enable_all(count_enable_all), .overflow_flags(overflow_flags));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one pulse per access, answer taken one cycle later
    task automatic access(input logic wr, input logic [4:0] idx,
                          input logic [63:0] wd);
        @(negedge ref_clk);
        sys_req = 1'b1;
        sys_write = wr;
        sys_index = idx;
        sys_wdata = wd;
        @(negedge ref_clk);
        sys_req = 1'b0;
        rd = sys_rdata;
        unm = sys_unmapped;
        chk({63'h0, sys_ack}, 64'h1);
    endtask : access
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        // ======================================================
        // identification and control after reset
        access(1'b0, 5'h00, 64'h0);
        chk(rd, 64'h3000);
        access(1'b0, 5'h06, 64'h0);
        chk(rd, 64'h00000a7f7fff0f3f);
        chk({44'h0, rd[63:44]}, 64'h0);
        chk({60'h0, rd[43], rd[41], rd[38], rd[37]}, 64'hf);
        chk({61'h0, rd[42], rd[40], rd[39]}, 64'h0);
        access(1'b0, 5'h07, 64'h0);
        chk(rd, 64'h00000000fef2ae7f);
        $display("test identification done");
        // ======================================================
        // control write, then a write to a read-only word
        access(1'b1, 5'h00, '1);
        // status copy lags the stored control bit by one edge
        @(negedge ref_clk);
        chk({63'h0, count_enable_all}, 64'h1);
        access(1'b0, 5'h00, 64'h0);
        chk(rd, 64'h307d);
        access(1'b1, 5'h00, 64'h0);
        @(negedge ref_clk);
        chk({63'h0, count_enable_all}, 64'h0);
        access(1'b1, 5'h06, '1);
        access(1'b0, 5'h06, 64'h0);
        chk(rd, 64'h00000a7f7fff0f3f);
        $display("test control done");
        // ======================================================
        // six counters hold 32 bits, upper half reads zero
        for (int i = 0; i < 6; i++) begin
            access(1'b1, 5'h10 + 5'(i), {32'hffffffff, 32'h5a000000 + i});
            access(1'b0, 5'h10 + 5'(i), 64'h0);
            chk(rd, {32'h0, 32'h5a000000 + i});
        end
        access(1'b0, 5'h1c, 64'h0);
        chk({63'h0, unm}, 64'h1);
        chk(rd, 64'h0);
        // counter 0 wraps on one event and raises its overflow flag
        access(1'b1, 5'h00, 64'h1);
        access(1'b1, 5'h01, 64'h1);
        access(1'b1, 5'h10, 64'hffffffff);
        @(negedge ref_clk);
        event_pulse = 6'h01;
        @(negedge ref_clk);
        event_pulse = 6'h00;
        chk({32'h0, overflow_flags}, 64'h1);
        access(1'b0, 5'h10, 64'h0);
        chk(rd, 64'h0);
        access(1'b1, 5'h00, 64'h0);
        $display("test counters done");
        // ======================================================
        // request held two cycles: the second cycle is refused
        @(negedge ref_clk);
        sys_req = 1'b1;
        sys_write = 1'b0;
        sys_index = 5'h06;
        @(negedge ref_clk);
        chk({63'h0, sys_ack}, 64'h1);
        @(negedge ref_clk);
        sys_req = 1'b0;
        chk({63'h0, sys_ack}, 64'h0);
        @(negedge ref_clk);
        chk({63'h0, sys_ack}, 64'h0);
        $display("test refusal done");
        report_and_stop();
    end
endmodule : pmr_register_bank_tb
bind pmr_register_bank pmr_register_bank_sva u_sva (.ref_clk(ref_clk),
    .arst_n(arst_n), .sys_req(sys_req), .sys_write(sys_write),
    .sys_index(sys_index), .sys_wdata(sys_wdata), .event_pulse(event_pulse),
    .sys_ack(sys_ack), .sys_rdata(sys_rdata),
    .sys_unmapped(sys_unmapped), .count_enable_all(count_enable_all),
    .overflow_flags(overflow_flags));
